// >>> rtl/csf_pkg.sv
// Package with constants and types for the core status flag register.
// Operation
// [RULE_01] The status register may be the destination of any instruction like any other register.
// [RULE_02] When a flag-updating instruction writes the status register, its flag results replace the written zero, digit carry and carry bits.
// [RULE_03] The time-out and power-down bits are read-only to instruction writes.
// [RULE_04] A file clear of the status register zeroes the three upper bits and sets the zero flag.
// [RULE_05] Software should alter the status register only with bit clear, bit set, nibble swap and move-to-register.
// [RULE_06] Software keeps the two reserved upper bits at zero; the block does not use them.
// [RULE_07] The bank select bit in position 5 picks bank 1 (80h-FFh) when set and bank 0 (00h-7Fh) when clear.
// [RULE_08] The active-low time-out bit 4 is set on power-up, watchdog clear and sleep, and cleared on a watchdog time-out.
// [RULE_09] The active-low power-down bit 3 is set on power-up and watchdog clear, and cleared by sleep.
// [RULE_10] The zero flag in bit 2 is set when an arithmetic or logic result is all zero and cleared otherwise.
// [RULE_11] For add and subtract the digit carry in bit 1 is the carry out of result bit 3.
// [RULE_12] For add and subtract the carry in bit 0 is the carry out of the most significant bit.
// [RULE_13] Subtraction adds the two's complement, so carry and digit carry mean no borrow when set.
// [RULE_14] Rotate right or left through carry loads carry with the low or high bit shifted out.
// [RULE_15] The status register answers at both 03h and 83h.
// [RULE_16] Flag updates commit in the write-back cycle and take priority over data written to the register.
package csf_pkg;
  localparam logic [7:0] STATUS_ADDR_B0 = 8'h03;
  localparam logic [7:0] STATUS_ADDR_B1 = 8'h83;
  localparam int         BIT_C     = 0;
  localparam int         BIT_DC    = 1;
  localparam int         BIT_Z     = 2;
  localparam int         BIT_PD    = 3;
  localparam int         BIT_TO    = 4;
  localparam int         BIT_BANK  = 5;
  localparam int         BIT_RSV_HI  = 6;
  localparam int         BIT_RSV_IND = 7;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] UPPER3_MASK  = 8'he0;

  typedef enum logic [3:0] {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_AND,
    CSF_OP_IOR,
    CSF_OP_XOR,
    CSF_OP_MOVE,
    CSF_OP_CLEAR,
    CSF_OP_COMP,
    CSF_OP_INC,
    CSF_OP_DEC,
    CSF_OP_RRC,
    CSF_OP_RLC,
    CSF_OP_SWAP,
    CSF_OP_PASS
  } csf_op_e;

  // Bank select prepended to a 7-bit direct address.
  function automatic logic [7:0] csf_direct_addr(input logic bank, input logic [6:0] low);
    csf_direct_addr = {bank, low};
  endfunction : csf_direct_addr
endpackage : csf_pkg

// >>> rtl/csf_alu.sv
// Eight-bit ALU that produces the result and the zero, digit carry and carry flags.
`timescale 1ns/1ps
module csf_alu (
  // Operation and operands
  input  csf_pkg::csf_op_e op,
  input  wire logic [7:0]  opnd_a,
  input  wire logic [7:0]  opnd_b,
  input  wire logic        carry_in,
  // Results
  output logic [7:0]       result,
  output logic             zero_upd,
  output logic             zero_out,
  output logic             carry_upd,
  output logic             carry_out,
  output logic             nibble_upd,
  output logic             nibble_carry_out
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [7:0] addend;

  always_comb begin
    // Subtraction adds the two's complement of b, so set carries mean no borrow.
    // [RULE_13] two's complement subtract
    addend = (op == csf_pkg::CSF_OP_SUB) ? ~opnd_b : opnd_b;
    lo_sum = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]}
           + {4'h0, (op == csf_pkg::CSF_OP_SUB)};
    hi_sum = {1'b0, opnd_a[7:4]} + {1'b0, addend[7:4]} + {4'h0, lo_sum[4]};
    result = opnd_a;
    zero_upd = 1'b0;
    carry_upd = 1'b0;
    carry_out = carry_in;
    nibble_upd = 1'b0;
    nibble_carry_out = 1'b0;
    case (op)
      csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB: begin
        result = {hi_sum[3:0], lo_sum[3:0]};
        zero_upd = 1'b1;
        // [RULE_11] digit carry out
        nibble_upd = 1'b1;
        nibble_carry_out = lo_sum[4];
        // [RULE_12] carry out of msb
        carry_upd = 1'b1;
        carry_out = hi_sum[4];
      end
      csf_pkg::CSF_OP_AND: begin
        result = opnd_a & opnd_b;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_IOR: begin
        result = opnd_a | opnd_b;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_XOR: begin
        result = opnd_a ^ opnd_b;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_MOVE: begin
        result = opnd_a;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_CLEAR: begin
        result = 8'h00;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_COMP: begin
        result = ~opnd_a;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_INC: begin
        result = opnd_a + 8'h01;
        zero_upd = 1'b1;
      end
      csf_pkg::CSF_OP_DEC: begin
        result = opnd_a - 8'h01;
        zero_upd = 1'b1;
      end
      // [RULE_14] rotate through carry
      csf_pkg::CSF_OP_RRC: begin
        result = {carry_in, opnd_a[7:1]};
        carry_upd = 1'b1;
        carry_out = opnd_a[0];
      end
      csf_pkg::CSF_OP_RLC: begin
        result = {opnd_a[6:0], carry_in};
        carry_upd = 1'b1;
        carry_out = opnd_a[7];
      end
      csf_pkg::CSF_OP_SWAP: result = {opnd_a[3:0], opnd_a[7:4]};
      csf_pkg::CSF_OP_PASS: result = opnd_b;
      default: result = opnd_a;
    endcase
    // [RULE_10] zero flag from result
    zero_out = (result == 8'h00);
  end
endmodule : csf_alu

// >>> rtl/csf_status_reg.sv
// Status flag register with ALU, write protection and bank select.
`timescale 1ns/1ps
module csf_status_reg (
  // Clock and control
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Instruction write-back
  input  wire logic        instr_valid,
  input  csf_pkg::csf_op_e instr_op,
  input  wire logic [7:0]  opnd_a,
  input  wire logic [7:0]  opnd_b,
  input  wire logic        dest_is_file,
  input  wire logic [6:0]  dest_addr_low,
  // Power events
  input  wire logic        watchdog_clear_instr,
  input  wire logic        sleep_instr,
  input  wire logic        watchdog_timeout,
  // Results
  output logic [7:0]       alu_result,
  output logic [7:0]       status_rd,
  output logic [7:0]       direct_addr,
  output logic             bank_select_bit
);
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] res_w;
  logic [7:0] result_q;
  logic       z_upd;
  logic       z_val;
  logic       c_upd;
  logic       c_val;
  logic       dc_upd;
  logic       dc_val;
  logic       hit_status;
  logic       wr_status;
  logic [7:0] result_d;
  logic       flag_op;

  csf_alu u_alu (
    .op               (instr_op),
    .opnd_a           (opnd_a),
    .opnd_b           (opnd_b),
    .carry_in         (status_q[csf_pkg::BIT_C]),
    .result           (res_w),
    .zero_upd         (z_upd),
    .zero_out         (z_val),
    .carry_upd        (c_upd),
    .carry_out        (c_val),
    .nibble_upd       (dc_upd),
    .nibble_carry_out (dc_val)
  );

  always_comb begin
    // [RULE_07] bank selects direct page
    direct_addr = csf_pkg::csf_direct_addr(status_q[csf_pkg::BIT_BANK], dest_addr_low);
    // [RULE_15] status seen at 03h and 83h
    hit_status = (direct_addr == csf_pkg::STATUS_ADDR_B0)
              || (direct_addr == csf_pkg::STATUS_ADDR_B1);
    wr_status = instr_valid && dest_is_file && hit_status;
    flag_op = z_upd || dc_upd || c_upd;
    status_d = status_q;
    result_d = result_q;
    // The result register follows executed instructions only, so it stays readable.
    if (instr_valid) result_d = res_w;
    // [RULE_01] plain write of the register
    if (wr_status) begin
      // [RULE_03] time-out and power-down protected
      status_d[7:5] = res_w[7:5];
      // [RULE_02] flag bits write-locked
      // An op that touches any flag blocks the write of all three, as a file clear shows.
      if (!flag_op) status_d[2:0] = res_w[2:0];
    end
    // [RULE_04] file clear on status
    if (wr_status && instr_op == csf_pkg::CSF_OP_CLEAR) begin
      status_d = status_q & ~csf_pkg::UPPER3_MASK;
    end
    // [RULE_16] flags override written data
    // [RULE_02] flag results replace write
    if (instr_valid) begin
      if (z_upd) status_d[csf_pkg::BIT_Z] = z_val;
      if (dc_upd) status_d[csf_pkg::BIT_DC] = dc_val;
      if (c_upd) status_d[csf_pkg::BIT_C] = c_val;
    end
    // [RULE_08] time-out flag events
    if (watchdog_clear_instr || sleep_instr) status_d[csf_pkg::BIT_TO] = 1'b1;
    if (watchdog_timeout) status_d[csf_pkg::BIT_TO] = 1'b0;
    // [RULE_09] power-down flag events
    if (watchdog_clear_instr) status_d[csf_pkg::BIT_PD] = 1'b1;
    if (sleep_instr) status_d[csf_pkg::BIT_PD] = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_q <= csf_pkg::STATUS_RESET;
      result_q <= 8'h00;
    end else if (clk_en) begin
      status_q <= status_d;
      result_q <= result_d;
    end
  end

  assign alu_result = result_q;
  assign status_rd = status_q;
  assign bank_select_bit = status_q[csf_pkg::BIT_BANK];

  // [RULE_08] reset loads flags
  // Reset is the one event that must not disable its own check.
  a_reset_value: assert property (@(posedge ref_clk) // [RULE_08]
    srst
    |=> status_q == csf_pkg::STATUS_RESET && result_q == 8'h00)
    else $error("reset value wrong");

  // [RULE_09] sleep clears power-down
  a_sleep_clears_pd: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_09]
    clk_en && sleep_instr
    |=> !status_q[csf_pkg::BIT_PD])
    else $error("power-down not cleared by sleep");

  // [RULE_09] watchdog clear sets power-down
  a_clear_sets_pd: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_09]
    clk_en && watchdog_clear_instr && !sleep_instr
    |=> status_q[csf_pkg::BIT_PD])
    else $error("power-down not set by watchdog clear");

  // [RULE_08] time-out clears flag
  a_wdt_clears_to: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_08]
    clk_en && watchdog_timeout
    |=> !status_q[csf_pkg::BIT_TO])
    else $error("time-out not cleared");

  // [RULE_08] clear or sleep sets
  a_event_sets_to: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_08]
    clk_en && (watchdog_clear_instr || sleep_instr) && !watchdog_timeout
    |=> status_q[csf_pkg::BIT_TO])
    else $error("time-out flag not set");

  // [RULE_03] protected bits hold
  a_to_pd_protect: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_03]
    clk_en && !watchdog_clear_instr && !sleep_instr && !watchdog_timeout
    |=> $stable(status_q[4:3]))
    else $error("protected bits changed");

  // [RULE_10] zero flag value
  a_zero_flag: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_10]
    clk_en && instr_valid && z_upd
    |=> status_q[csf_pkg::BIT_Z] == (result_q == 8'h00))
    else $error("zero flag mismatch");

  // [RULE_10] no flags otherwise
  a_no_flag_ops: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_10]
    clk_en && instr_valid && !wr_status
    && (instr_op == csf_pkg::CSF_OP_SWAP || instr_op == csf_pkg::CSF_OP_PASS)
    |=> $stable(status_q[2:0]))
    else $error("flags changed by a flag-free op");

  // [RULE_12] add carry out
  a_add_carry: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_12]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_ADD
    |=> status_q[csf_pkg::BIT_C] == (({1'b0, $past(opnd_a)} + {1'b0, $past(opnd_b)}) > 9'h0ff))
    else $error("add carry wrong");

  // [RULE_11] add digit carry
  a_add_nibble: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_11]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_ADD
    |=> status_q[csf_pkg::BIT_DC] ==
        (({1'b0, $past(opnd_a[3:0])} + {1'b0, $past(opnd_b[3:0])}) > 5'h0f))
    else $error("digit carry wrong");

  // [RULE_13] subtract carry polarity
  a_sub_borrow: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_13]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_SUB
    |=> status_q[csf_pkg::BIT_C] == ($past(opnd_a) >= $past(opnd_b)))
    else $error("sub borrow polarity wrong");

  // [RULE_13] subtract digit polarity
  a_sub_nibble: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_13]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_SUB
    |=> status_q[csf_pkg::BIT_DC] == ($past(opnd_a[3:0]) >= $past(opnd_b[3:0])))
    else $error("sub digit borrow polarity wrong");

  // [RULE_14] rotate right carry
  a_rotate_carry: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_14]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_RRC
    |=> status_q[csf_pkg::BIT_C] == $past(opnd_a[0]))
    else $error("rotate carry wrong");

  // [RULE_14] rotate left carry
  a_rotate_left: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_14]
    clk_en && instr_valid && instr_op == csf_pkg::CSF_OP_RLC
    |=> status_q[csf_pkg::BIT_C] == $past(opnd_a[7]))
    else $error("rotate left carry wrong");

  // [RULE_04] file clear result
  a_clear_status: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_04]
    clk_en && wr_status && instr_op == csf_pkg::CSF_OP_CLEAR
    |=> status_q[7:5] == 3'h0 && status_q[csf_pkg::BIT_Z])
    else $error("file clear of status wrong");

  // [RULE_01] plain status write
  a_status_write: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_01]
    clk_en && wr_status && !flag_op
    |=> status_q[7:5] == result_q[7:5] && status_q[2:0] == result_q[2:0])
    else $error("status write lost");

  // [RULE_02] carry write locked
  a_write_keeps_c: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_02]
    clk_en && wr_status && flag_op && !c_upd
    |=> $stable(status_q[csf_pkg::BIT_C]))
    else $error("carry written by a flag op");

  // [RULE_02] digit carry locked
  a_write_keeps_dc: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_02]
    clk_en && wr_status && flag_op && !dc_upd
    |=> $stable(status_q[csf_pkg::BIT_DC]))
    else $error("digit carry written by a flag op");

  // [RULE_16] flag beats data
  a_flag_commit: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_16]
    clk_en && instr_valid && c_upd
    |=> status_q[csf_pkg::BIT_C] == $past(c_val))
    else $error("carry result not committed");

  // [RULE_16] result register hold
  a_result_hold: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_16]
    clk_en && !instr_valid
    |=> $stable(result_q))
    else $error("result changed without an instruction");

  // [RULE_16] enable freezes state
  a_frozen_state: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_16]
    !clk_en
    |=> $stable(status_q) && $stable(result_q))
    else $error("state changed while disabled");

  // [RULE_15] both status aliases
  a_status_alias: assert property (@(posedge ref_clk) disable iff (srst) // [RULE_15]
    dest_addr_low == 7'h03
    |-> hit_status)
    else $error("status alias missed");

  // [RULE_07] bank picks page
  a_bank_addr: assert property (@(posedge ref_clk) // [RULE_07]
    direct_addr[7] == status_q[csf_pkg::BIT_BANK] && bank_select_bit == status_q[5])
    else $error("bank address wrong");

  c_sub_status: cover property (@(posedge ref_clk) disable iff (srst)
    clk_en && wr_status && instr_op == csf_pkg::CSF_OP_SUB);
  c_sleep: cover property (@(posedge ref_clk) disable iff (srst) clk_en && sleep_instr);
  c_bank1_hit: cover property (@(posedge ref_clk) disable iff (srst)
    wr_status && status_q[csf_pkg::BIT_BANK]);
  c_flag_write: cover property (@(posedge ref_clk) disable iff (srst)
    clk_en && wr_status && flag_op && !c_upd);
  c_frozen: cover property (@(posedge ref_clk) disable iff (srst)
    !clk_en && instr_valid);
endmodule : csf_status_reg

// >>> verification/csf_exec_model.sv
// Behavioural model of the instruction execution logic that feeds the status block.
`timescale 1ns/1ps
module csf_exec_model (
  // Clock
  input  wire logic        ref_clk,
  // Instruction write-back
  output logic             clk_en,
  output logic             instr_valid,
  output csf_pkg::csf_op_e instr_op,
  output logic [7:0]       opnd_a,
  output logic [7:0]       opnd_b,
  output logic             dest_is_file,
  output logic [6:0]       dest_addr_low,
  // Power events
  output logic             watchdog_clear_instr,
  output logic             sleep_instr,
  output logic             watchdog_timeout
);
  initial begin
    clk_en = 1'b1;
    {instr_valid, dest_is_file, watchdog_clear_instr, sleep_instr, watchdog_timeout} = 5'h00;
    instr_op = csf_pkg::CSF_OP_NONE;
    {opnd_a, opnd_b, dest_addr_low} = 23'h000000;
  end

  // Drives one instruction for one cycle, launched and dropped at falling edges.
  task automatic exec(input csf_pkg::csf_op_e op, input logic [7:0] a, input logic [7:0] b,
                      input logic to_file, input logic [6:0] low);
    @(negedge ref_clk);
    instr_op = op;
    opnd_a = (to_file && low == 7'h03) ? (a & 8'hf3) : a;
    opnd_b = b;
    dest_is_file = to_file;
    dest_addr_low = low;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    dest_is_file = 1'b0;
  endtask : exec

  task automatic pulse(input logic wc, input logic sl, input logic wt);
    @(negedge ref_clk);
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = {wc, sl, wt};
    @(negedge ref_clk);
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
  endtask : pulse
endmodule : csf_exec_model

// >>> verification/testbench.sv
// Self-checking testbench for the status flag register.
`timescale 1ns/1ps
module testbench;
  logic             ref_clk = 1'b0;
  logic             srst    = 1'b1;
  logic             clk_en, instr_valid, dest_is_file, wclr, slp, wto, bank_select_bit;
  csf_pkg::csf_op_e instr_op;
  logic [7:0]       opnd_a, opnd_b, alu_result, status_rd, direct_addr;
  logic [6:0]       dest_addr_low;
  int               failures = 0;
  int               n_tests  = 0;

  always #12.5 ref_clk = ~ref_clk;

  csf_exec_model csf_exec_model_i (.ref_clk(ref_clk), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_op(instr_op), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .dest_is_file(dest_is_file), .dest_addr_low(dest_addr_low),
    .watchdog_clear_instr(wclr), .sleep_instr(slp), .watchdog_timeout(wto));

  csf_status_reg csf_status_reg_i (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_op(instr_op), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .dest_is_file(dest_is_file), .dest_addr_low(dest_addr_low),
    .watchdog_clear_instr(wclr), .sleep_instr(slp), .watchdog_timeout(wto),
    .alu_result(alu_result), .status_rd(status_rd), .direct_addr(direct_addr),
    .bank_select_bit(bank_select_bit));

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    chk8("reset status", 8'h18, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_ADD, 8'h0f, 8'h01, 1'b0, 7'h00);
    chk8("add status", 8'h1a, status_rd);
    chk8("add result", 8'h10, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_ADD, 8'hff, 8'h01, 1'b0, 7'h00);
    chk8("add wrap status", 8'h1f, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05, 1'b0, 7'h00);
    chk8("sub equal status", 8'h1f, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SUB, 8'h00, 8'h01, 1'b0, 7'h00);
    chk8("sub borrow status", 8'h18, status_rd);
    chk8("sub result", 8'hff, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_RRC, 8'h01, 8'h00, 1'b0, 7'h00);
    chk8("rrc carry", 8'h01, {7'h00, status_rd[0]});
    chk8("rrc result", 8'h00, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_RLC, 8'h40, 8'h00, 1'b0, 7'h00);
    chk8("rlc carry", 8'h00, {7'h00, status_rd[0]});
    chk8("rlc result", 8'h81, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_ADD, 8'h0f, 8'h01, 1'b0, 7'h00);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SWAP, 8'hb2, 8'h00, 1'b1, 7'h03);
    chk8("swap write status", 8'h3b, status_rd);
    chk8("bank bit", 8'h01, {7'h00, bank_select_bit});
    csf_exec_model_i.dest_addr_low = 7'h05;
    #1;
    chk8("bank 1 address", 8'h85, direct_addr);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SWAP, 8'h20, 8'h00, 1'b1, 7'h03);
    chk8("write via 83h", 8'h1a, status_rd);
    chk8("bank 0 address", 8'h03, direct_addr);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_ADD, 8'h20, 8'he0, 1'b1, 7'h03);
    chk8("add into status", 8'h1d, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SWAP, 8'h22, 8'h00, 1'b1, 7'h03);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_CLEAR, 8'h3a, 8'h00, 1'b1, 7'h03);
    chk8("clear status", 8'h1e, status_rd);
    csf_exec_model_i.pulse(1'b0, 1'b1, 1'b0);
    chk8("sleep", 8'h16, status_rd);
    csf_exec_model_i.pulse(1'b0, 1'b0, 1'b1);
    chk8("timeout", 8'h06, status_rd);
    csf_exec_model_i.pulse(1'b1, 1'b0, 1'b0);
    chk8("watchdog clear", 8'h1e, status_rd);
    csf_exec_model_i.pulse(1'b1, 1'b0, 1'b1);
    chk8("timeout and clear", 8'h0e, status_rd);
    csf_exec_model_i.pulse(1'b1, 1'b1, 1'b0);
    chk8("sleep and clear", 8'h16, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_SWAP, 8'h81, 8'h00, 1'b1, 7'h03);
    chk8("read-only bits", 8'h10, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_AND, 8'hf0, 8'h0f, 1'b0, 7'h00);
    chk8("and zero status", 8'h14, status_rd);
    chk8("and result", 8'h00, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_IOR, 8'h0a, 8'h50, 1'b0, 7'h00);
    chk8("ior status", 8'h10, status_rd);
    chk8("ior result", 8'h5a, alu_result);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_XOR, 8'h3c, 8'h3c, 1'b0, 7'h00);
    chk8("xor zero status", 8'h14, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_MOVE, 8'h7e, 8'h00, 1'b0, 7'h00);
    chk8("move result", 8'h7e, alu_result);
    chk8("move status", 8'h10, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_COMP, 8'hff, 8'h00, 1'b0, 7'h00);
    chk8("comp zero status", 8'h14, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_INC, 8'h7f, 8'h00, 1'b0, 7'h00);
    chk8("inc result", 8'h80, alu_result);
    chk8("inc status", 8'h10, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_DEC, 8'h01, 8'h00, 1'b0, 7'h00);
    chk8("dec zero status", 8'h14, status_rd);
    csf_exec_model_i.exec(csf_pkg::CSF_OP_PASS, 8'h00, 8'h25, 1'b1, 7'h03);
    chk8("pass into status", 8'h35, status_rd);
    chk8("pass bank bit", 8'h01, {7'h00, bank_select_bit});
    csf_exec_model_i.exec(csf_pkg::CSF_OP_AND, 8'hc2, 8'h02, 1'b1, 7'h03);
    chk8("and into status", 8'h11, status_rd);
    chk8("and into result", 8'h02, alu_result);
    csf_exec_model_i.clk_en = 1'b0;
    csf_exec_model_i.exec(csf_pkg::CSF_OP_ADD, 8'hff, 8'h01, 1'b0, 7'h00);
    chk8("frozen status", 8'h11, status_rd);
    chk8("frozen result", 8'h02, alu_result);
    csf_exec_model_i.clk_en = 1'b1;
    srst = 1'b1;
    @(negedge ref_clk);
    srst = 1'b0;
    chk8("second reset status", 8'h18, status_rd);
    chk8("second reset result", 8'h00, alu_result);
    summarize();
  end
endmodule : testbench
